// ### dabf_pkg.sv
// package for the dac adaptive biquad filter block: map, field positions, types
// assumes an 8-bit paged register port and 16-bit stereo samples
package dabf_pkg;
	localparam int DATA_W = 16;
	localparam int COEF_W = 16;
	localparam int FRAC_BITS = 15;
	localparam int ACC_W = 37;
	localparam int NUM_BQ = 6;
	localparam int BQ_TAPS = 5;
	localparam int IIR_TAPS = 3;
	localparam int CH_BQ_COEF = 30;
	localparam int IIR_BASE = 60;
	localparam int NUM_COEF = 66;
	localparam int IIR_HIST = 6;
	localparam logic [7:0] PAGE_CTRL = 8'h00;
	localparam logic [7:0] PAGE_A_BQ = 8'h08;
	localparam logic [7:0] PAGE_A_IIR = 8'h09;
	localparam logic [7:0] PAGE_B_BQ = 8'h0c;
	localparam logic [7:0] PAGE_B_IIR = 8'h0d;
	localparam logic [6:0] REG_BANK_CTRL = 7'h01;
	localparam logic [6:0] REG_DAC_POWER = 7'h3f;
	localparam logic [6:0] REG_CHAIN_SEL = 7'h10;
	localparam logic [6:0] BQ_L_FIRST = 7'h02;
	localparam logic [6:0] BQ_L_LAST = 7'h3d;
	localparam logic [6:0] BQ_R_FIRST = 7'h42;
	localparam logic [6:0] BQ_R_LAST = 7'h7d;
	localparam logic [6:0] IIR_L_FIRST = 7'h02;
	localparam logic [6:0] IIR_R_FIRST = 7'h08;
	localparam logic [6:0] IIR_R_LAST = 7'h0d;
	localparam int BIT_SWAP = 0;
	localparam int BIT_BANK = 1;
	localparam int BIT_ADAPT = 2;
	localparam int BIT_PWR_R = 6;
	localparam int BIT_PWR_L = 7;
	localparam logic [15:0] COEF_NUM0_RST = 16'h7fff;
	localparam logic [15:0] COEF_OTHER_RST = 16'h0000;
	localparam logic [7:0] CHAIN_RST = 8'h01;
	localparam logic [7:0] POWER_RST = 8'h00;
	localparam logic signed [15:0] SAMPLE_MAX = 16'sh7fff;
	localparam logic signed [15:0] SAMPLE_MIN = -16'sh8000;

	typedef struct packed {
		logic signed [DATA_W-1:0] left;
		logic signed [DATA_W-1:0] right;
	} dabf_sample_t;

	typedef struct packed {
		logic valid;
		logic bank;
		logic [6:0] idx;
		logic hi;
	} dabf_coef_loc_t;

	typedef struct packed {
		logic [2:0] nbq;
		logic iir_en;
	} dabf_chain_t;
endpackage

// ### dabf_fifo.sv
// sample fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module dabf_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rp_q];

	always_ff @(posedge clk) begin
		if (srst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			in_ready <= 1'b1;
		end else begin
			if (push) begin
				mem_q[wp_q] <= in_data;
				wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
			end
			cnt_q <= cnt_d;
			in_ready <= (cnt_d != (AW+1)'(DEPTH));
		end
	end
endmodule

// ### dabf_top.sv
// adaptive biquad playback filter: coefficient banks, bank swap, filter engine
// assumes a paged 8-bit register port and samples synchronous to clk
`timescale 1ns/1ps
module dabf_top #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] reg_page,
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic in_valid,
	output logic in_ready,
	input wire dabf_pkg::dabf_sample_t in_sample,
	output logic out_valid,
	output dabf_pkg::dabf_sample_t out_sample
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN = 3'b010,
		ST_DONE = 3'b100
	} dabf_state_t;

	function automatic dabf_pkg::dabf_coef_loc_t decode(input logic [7:0] pg, input logic [6:0] ra);
		dabf_pkg::dabf_coef_loc_t l;
		logic [6:0] off;
		l = '0;
		off = '0;
		l.bank = (pg == dabf_pkg::PAGE_B_BQ) || (pg == dabf_pkg::PAGE_B_IIR);
		l.hi = ~ra[0];
		if (pg == dabf_pkg::PAGE_A_BQ || pg == dabf_pkg::PAGE_B_BQ) begin
			if (ra >= dabf_pkg::BQ_L_FIRST && ra <= dabf_pkg::BQ_L_LAST) begin
				off = ra - dabf_pkg::BQ_L_FIRST;
				l.valid = 1'b1;
				l.idx = {1'b0, off[6:1]};
			end else if (ra >= dabf_pkg::BQ_R_FIRST && ra <= dabf_pkg::BQ_R_LAST) begin
				off = ra - dabf_pkg::BQ_R_FIRST;
				l.valid = 1'b1;
				l.idx = 7'(dabf_pkg::CH_BQ_COEF) + {1'b0, off[6:1]};
			end
		end else if (pg == dabf_pkg::PAGE_A_IIR || pg == dabf_pkg::PAGE_B_IIR) begin
			if (ra >= dabf_pkg::IIR_L_FIRST && ra <= dabf_pkg::IIR_R_LAST) begin
				off = ra - dabf_pkg::IIR_L_FIRST;
				l.valid = 1'b1;
				l.idx = 7'(dabf_pkg::IIR_BASE) + {1'b0, off[6:1]};
			end
		end
		return l;
	endfunction

	function automatic dabf_pkg::dabf_chain_t chain_cfg(input logic [7:0] c);
		dabf_pkg::dabf_chain_t r;
		case (c)
			8'h01, 8'h04: r = '{nbq: 3'h3, iir_en: 1'b0};
			8'h07, 8'h0c, 8'h11, 8'h14: r = '{nbq: 3'h0, iir_en: 1'b1};
			8'h08, 8'h09, 8'h0d, 8'h0e: r = '{nbq: 3'h4, iir_en: 1'b0};
			8'h12, 8'h15: r = '{nbq: 3'h4, iir_en: 1'b1};
			8'h13, 8'h16: r = '{nbq: 3'h4, iir_en: 1'b1};
			8'h17: r = '{nbq: 3'h2, iir_en: 1'b0};
			8'h18, 8'h19: r = '{nbq: 3'h5, iir_en: 1'b1};
			default: r = '{nbq: 3'h6, iir_en: 1'b1};
		endcase
		return r;
	endfunction

	function automatic logic signed [15:0] sat(input logic signed [dabf_pkg::ACC_W-1:0] a);
		logic signed [dabf_pkg::ACC_W-1:0] s;
		s = a >>> dabf_pkg::FRAC_BITS;
		if (s > dabf_pkg::ACC_W'(dabf_pkg::SAMPLE_MAX)) return dabf_pkg::SAMPLE_MAX;
		if (s < dabf_pkg::ACC_W'(dabf_pkg::SAMPLE_MIN)) return dabf_pkg::SAMPLE_MIN;
		return s[15:0];
	endfunction

	// coefficient banks and control
	logic [15:0] coef_q [2][dabf_pkg::NUM_COEF];
	logic adaptive_q;
	logic bank_sel_q;
	logic swap_req_q;
	logic [7:0] power_q;
	logic [7:0] chain_q;
	dabf_state_t state_q;
	logic [2:0] sec_q;
	logic [2:0] steps_q;
	logic [2:0] nbq_q;
	dabf_pkg::dabf_sample_t cur_q;

	dabf_pkg::dabf_coef_loc_t loc;
	assign loc = decode(reg_page, reg_addr);
	wire dac_running = power_q[dabf_pkg::BIT_PWR_L] | power_q[dabf_pkg::BIT_PWR_R];
	wire coef_locked = dac_running && !adaptive_q;
	wire coef_we = reg_wr && loc.valid && !coef_locked;
	wire wr_bank = dac_running ? ~bank_sel_q : loc.bank;
	wire sel_ctrl = reg_page == dabf_pkg::PAGE_A_BQ && reg_addr == dabf_pkg::REG_BANK_CTRL;
	wire sel_power = reg_page == dabf_pkg::PAGE_CTRL && reg_addr == dabf_pkg::REG_DAC_POWER;
	wire sel_chain = reg_page == dabf_pkg::PAGE_CTRL && reg_addr == dabf_pkg::REG_CHAIN_SEL;
	wire ctrl_wr = reg_wr && sel_ctrl;
	wire host_swap_set = ctrl_wr && reg_wdata[dabf_pkg::BIT_SWAP] && adaptive_q && dac_running;
	wire fifo_valid;
	dabf_pkg::dabf_sample_t fifo_data;
	wire sample_start = (state_q == ST_IDLE) && fifo_valid && dac_running;
	wire swap_now = sample_start && swap_req_q;
	dabf_pkg::dabf_chain_t cfg;
	assign cfg = chain_cfg(chain_q);
	wire [15:0] rd_coef = coef_q[loc.bank][loc.idx];

	dabf_fifo #(
		.WIDTH($bits(dabf_pkg::dabf_sample_t)),
		.DEPTH(FIFO_DEPTH)
	) i_dabf_fifo (
		.clk(clk),
		.srst(srst),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data(in_sample),
		.out_valid(fifo_valid),
		.out_ready(sample_start),
		.out_data(fifo_data)
	);

	always_ff @(posedge clk) begin
		if (srst) begin
			for (int b = 0; b < 2; b++) begin
				for (int i = 0; i < dabf_pkg::NUM_COEF; i++) begin
					coef_q[b][i] <= ((i < dabf_pkg::IIR_BASE && i % dabf_pkg::BQ_TAPS == 0) ||
						(i >= dabf_pkg::IIR_BASE && (i - dabf_pkg::IIR_BASE) % dabf_pkg::IIR_TAPS == 0)) ?
						dabf_pkg::COEF_NUM0_RST : dabf_pkg::COEF_OTHER_RST;
				end
			end
		end else if (coef_we) begin
			if (loc.hi) coef_q[wr_bank][loc.idx][15:8] <= reg_wdata;
			else coef_q[wr_bank][loc.idx][7:0] <= reg_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			adaptive_q <= 1'b0;
			bank_sel_q <= 1'b0;
			swap_req_q <= 1'b0;
			power_q <= dabf_pkg::POWER_RST;
			chain_q <= dabf_pkg::CHAIN_RST;
		end else begin
			if (ctrl_wr) adaptive_q <= reg_wdata[dabf_pkg::BIT_ADAPT];
			if (reg_wr && sel_power) power_q <= reg_wdata;
			if (reg_wr && sel_chain) chain_q <= reg_wdata;
			if (swap_now) bank_sel_q <= ~bank_sel_q;
			swap_req_q <= (swap_req_q && !swap_now && dac_running && adaptive_q) | host_swap_set;
		end
	end

	// register read port, one cycle latency
	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata <= '0;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				if (sel_ctrl)
					reg_rdata <= {5'h00, adaptive_q, bank_sel_q, swap_req_q};
				else if (sel_power)
					reg_rdata <= power_q;
				else if (sel_chain)
					reg_rdata <= chain_q;
				else if (loc.valid && !coef_locked)
					reg_rdata <= loc.hi ? rd_coef[15:8] : rd_coef[7:0];
				else
					reg_rdata <= 8'h00;
			end
		end
	end

	// filter engine: one section per cycle, both channels in parallel
	wire sec_is_iir = (sec_q >= nbq_q);
	wire [2:0] hidx = sec_is_iir ? 3'(dabf_pkg::IIR_HIST) : sec_q;
	wire last_step = (sec_q + 3'h1 >= steps_q);
	logic signed [15:0] y_ch [2];

	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		logic signed [15:0] hx1_q [7];
		logic signed [15:0] hx2_q [7];
		logic signed [15:0] hy1_q [7];
		logic signed [15:0] hy2_q [7];
		wire [6:0] cbase = sec_is_iir ? 7'(dabf_pkg::IIR_BASE + ch * dabf_pkg::IIR_TAPS) :
			7'(ch * dabf_pkg::CH_BQ_COEF) + 7'(sec_q) * 7'(dabf_pkg::BQ_TAPS);
		wire signed [15:0] c0 = coef_q[bank_sel_q][cbase];
		wire signed [15:0] c1 = coef_q[bank_sel_q][cbase + 7'h1];
		wire signed [15:0] c2 = coef_q[bank_sel_q][cbase + 7'h2];
		wire signed [15:0] c3 = sec_is_iir ? 16'sh0000 : coef_q[bank_sel_q][cbase + 7'h3];
		wire signed [15:0] c4 = sec_is_iir ? 16'sh0000 : coef_q[bank_sel_q][cbase + 7'h4];
		wire signed [15:0] x = (ch == 0) ? cur_q.left : cur_q.right;
		wire signed [dabf_pkg::ACC_W-1:0] p0 = dabf_pkg::ACC_W'(c0 * x);
		wire signed [dabf_pkg::ACC_W-1:0] p1 = dabf_pkg::ACC_W'(c1 * hx1_q[hidx]);
		wire signed [dabf_pkg::ACC_W-1:0] p2 = dabf_pkg::ACC_W'(c2 * (sec_is_iir ? hy1_q[hidx] : hx2_q[hidx]));
		wire signed [dabf_pkg::ACC_W-1:0] p3 = dabf_pkg::ACC_W'(c3 * hy1_q[hidx]);
		wire signed [dabf_pkg::ACC_W-1:0] p4 = dabf_pkg::ACC_W'(c4 * hy2_q[hidx]);
		wire signed [dabf_pkg::ACC_W-1:0] acc_iir = p0 + p1 + p2;
		wire signed [dabf_pkg::ACC_W-1:0] acc_bq = p0 + (p1 <<< 1) + p2 + (p3 <<< 1) + p4;
		assign y_ch[ch] = sat(sec_is_iir ? acc_iir : acc_bq);

		always_ff @(posedge clk) begin
			if (srst) begin
				for (int s = 0; s < 7; s++) begin
					hx1_q[s] <= '0;
					hx2_q[s] <= '0;
					hy1_q[s] <= '0;
					hy2_q[s] <= '0;
				end
			end else if (state_q == ST_RUN) begin
				hx1_q[hidx] <= x;
				hx2_q[hidx] <= hx1_q[hidx];
				hy1_q[hidx] <= y_ch[ch];
				hy2_q[hidx] <= hy1_q[hidx];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= ST_IDLE;
			sec_q <= '0;
			steps_q <= '0;
			nbq_q <= '0;
			cur_q <= '0;
			out_valid <= 1'b0;
			out_sample <= '0;
		end else begin
			out_valid <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (sample_start) begin
						cur_q <= fifo_data;
						sec_q <= '0;
						nbq_q <= cfg.nbq;
						steps_q <= cfg.nbq + 3'(cfg.iir_en);
						state_q <= (cfg.nbq == 3'h0 && !cfg.iir_en) ? ST_DONE : ST_RUN;
					end
				end
				ST_RUN: begin
					cur_q <= '{left: y_ch[0], right: y_ch[1]};
					sec_q <= sec_q + 3'h1;
					if (last_step) state_q <= ST_DONE;
				end
				ST_DONE: begin
					out_valid <= 1'b1;
					out_sample <= cur_q;
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// checks
	a_locked_no_write: assert property (@(posedge clk) disable iff (srst)
		(reg_wr && loc.valid && dac_running && !adaptive_q)
		|=> (coef_q[0][$past(loc.idx)] == $past(coef_q[0][loc.idx])
		&& coef_q[1][$past(loc.idx)] == $past(coef_q[1][loc.idx])))
		else $error("coefficient written while locked");
	a_adaptive_write: assert property (@(posedge clk) disable iff (srst)
		(reg_wr && loc.valid && loc.hi && dac_running && adaptive_q)
		|=> coef_q[~$past(bank_sel_q)][$past(loc.idx)][15:8] == $past(reg_wdata))
		else $error("adaptive write refused");
	a_running_idle_bank: assert property (@(posedge clk) disable iff (srst)
		(reg_wr && loc.valid && dac_running)
		|=> coef_q[$past(bank_sel_q)][$past(loc.idx)] == $past(coef_q[bank_sel_q][loc.idx]))
		else $error("running write hit active bank");
	a_stopped_addr_bank: assert property (@(posedge clk) disable iff (srst)
		(reg_wr && loc.valid && !loc.hi && !dac_running)
		|=> coef_q[$past(reg_page == dabf_pkg::PAGE_B_BQ || reg_page == dabf_pkg::PAGE_B_IIR)][$past(loc.idx)][7:0]
		== $past(reg_wdata))
		else $error("stopped write missed addressed bank");
	a_stopped_high_byte: assert property (@(posedge clk) disable iff (srst)
		(reg_wr && loc.valid && loc.hi && !dac_running)
		|=> coef_q[$past(loc.bank)][$past(loc.idx)][15:8] == $past(reg_wdata))
		else $error("coefficient high byte not stored");
	a_locked_read_zero: assert property (@(posedge clk) disable iff (srst)
		(reg_rd && loc.valid && dac_running && !adaptive_q) |=> reg_rdata == 8'h00)
		else $error("locked coefficient read not blocked");
	a_coef_readback: assert property (@(posedge clk) disable iff (srst)
		(reg_rd && loc.valid && !(dac_running && !adaptive_q))
		|=> reg_rdata == ($past(loc.hi) ? $past(coef_q[loc.bank][loc.idx][15:8])
		: $past(coef_q[loc.bank][loc.idx][7:0])))
		else $error("coefficient readback wrong");
	a_unmapped_read: assert property (@(posedge clk) disable iff (srst)
		(reg_rd && !loc.valid && !sel_ctrl && !sel_power && !sel_chain) |=> reg_rdata == 8'h00)
		else $error("unmapped register read not zero");
	a_rd_answer: assert property (@(posedge clk) disable iff (srst)
		reg_rd |=> reg_rvalid)
		else $error("read not answered");
	a_adapt_bit: assert property (@(posedge clk) disable iff (srst)
		ctrl_wr |=> adaptive_q == $past(reg_wdata[dabf_pkg::BIT_ADAPT]))
		else $error("adaptive bit not stored");
	// bank swap, coefficient reset and section count checks
	a_swap_needs_adapt: assert property (@(posedge clk) disable iff (srst)
		$rose(swap_req_q) |-> $past(adaptive_q && dac_running))
		else $error("swap request taken outside adaptive run");
	a_bank_hold_stopped: assert property (@(posedge clk) disable iff (srst)
		!dac_running |=> $stable(bank_sel_q))
		else $error("bank changed while stopped");
	a_swap_toggles_bank: assert property (@(posedge clk) disable iff (srst)
		swap_now |=> (bank_sel_q != $past(bank_sel_q)))
		else $error("bank not toggled on swap");
	a_bank_only_at_start: assert property (@(posedge clk) disable iff (srst)
		(bank_sel_q != $past(bank_sel_q)) |-> $past(sample_start && swap_req_q))
		else $error("bank changed outside sample start");
	a_swap_self_clear: assert property (@(posedge clk) disable iff (srst)
		(swap_now && !host_swap_set) |=> !swap_req_q)
		else $error("swap request not cleared");
	a_bank_readback: assert property (@(posedge clk) disable iff (srst)
		(reg_rd && reg_page == dabf_pkg::PAGE_A_BQ && reg_addr == dabf_pkg::REG_BANK_CTRL)
		|=> reg_rdata[dabf_pkg::BIT_BANK] == $past(bank_sel_q))
		else $error("bank-in-use readback wrong");
	a_reset_coefs: assert property (@(posedge clk)
		$fell(srst) |-> (coef_q[1][0] == dabf_pkg::COEF_NUM0_RST && coef_q[0][1] == dabf_pkg::COEF_OTHER_RST
		&& coef_q[0][dabf_pkg::IIR_BASE] == dabf_pkg::COEF_NUM0_RST))
		else $error("coefficient reset values wrong");
	a_section_bound: assert property (@(posedge clk) disable iff (srst)
		(state_q == ST_RUN) |-> (sec_q < 3'(dabf_pkg::NUM_BQ + 1)) ##[1:7] (state_q == ST_DONE))
		else $error("section count out of range");
	// engine checks
	a_chain_four: assert property (@(posedge clk) disable iff (srst)
		(sample_start && chain_q inside {8'h12, 8'h13, 8'h15, 8'h16})
		|=> (nbq_q == 3'h4 && steps_q == 3'h5))
		else $error("four biquad chain misconfigured");
	a_chain_two: assert property (@(posedge clk) disable iff (srst)
		(sample_start && chain_q == 8'h17) |=> (nbq_q == 3'h2 && steps_q == 3'h2))
		else $error("two biquad chain misconfigured");
	a_chain_five: assert property (@(posedge clk) disable iff (srst)
		(sample_start && chain_q == 8'h19) |=> (nbq_q == 3'h5 && steps_q == 3'h6))
		else $error("five biquad chain misconfigured");
	a_stopped_no_pop: assert property (@(posedge clk) disable iff (srst)
		(state_q == ST_IDLE && fifo_valid && !power_q[dabf_pkg::BIT_PWR_L] && !power_q[dabf_pkg::BIT_PWR_R])
		|=> (state_q == ST_IDLE))
		else $error("sample processed while dac stopped");
	a_iir_after_bq: assert property (@(posedge clk) disable iff (srst)
		(state_q == ST_RUN && sec_is_iir) |-> last_step)
		else $error("first-order section not last");
	a_bq_limit: assert property (@(posedge clk) disable iff (srst)
		sample_start |=> (nbq_q <= 3'h6))
		else $error("too many biquads");
	c_swap: cover property (@(posedge clk) disable iff (srst) swap_now);
	c_locked_write: cover property (@(posedge clk) disable iff (srst) reg_wr && loc.valid && coef_locked);
	c_sample_out: cover property (@(posedge clk) disable iff (srst) out_valid && bank_sel_q);
	c_adaptive_write: cover property (@(posedge clk) disable iff (srst) coef_we && dac_running);
	c_four_bq_iir: cover property (@(posedge clk) disable iff (srst) sample_start && cfg.nbq == 3'h4 && cfg.iir_en);
endmodule

// ### dabf_host.sv
// host model: drives the paged byte register port of the filter block
// assumes one clock; strobes launched 1 ns after the rising edge
`timescale 1ns/1ps
module dabf_host (
	input wire logic clk,
	output logic [7:0] reg_page,
	output logic [6:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	logic rd_ok;
	initial begin
		reg_page = 8'h00;
		reg_addr = 7'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
		rd_ok = 1'b0;
	end
	// strobes drop low; released page, address and data lines show the inverse of the last value
	task automatic release_bus();
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_page = ~reg_page;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
	endtask
	task automatic wr(input logic [7:0] page, input logic [6:0] addr, input logic [7:0] data);
		@(posedge clk);
		#1;
		reg_page = page;
		reg_addr = addr;
		reg_wdata = data;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		release_bus();
	endtask
	// answer registered at the taking edge, read just after it
	task automatic rd(input logic [7:0] page, input logic [6:0] addr, output logic [7:0] data);
		@(posedge clk);
		#1;
		reg_page = page;
		reg_addr = addr;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		data = reg_rdata;
		rd_ok = reg_rvalid;
		release_bus();
	endtask
	// high byte on the even register, low byte on the next
	task automatic wcoef(input logic [7:0] page, input logic [6:0] addr, input logic [15:0] v);
		wr(page, addr, v[15:8]);
		wr(page, addr + 7'h01, v[7:0]);
	endtask
	task automatic rcoef(input logic [7:0] page, input logic [6:0] addr, output logic [15:0] v);
		rd(page, addr, v[15:8]);
		rd(page, addr + 7'h01, v[7:0]);
	endtask
endmodule

// ### dabf_top_bench.sv
// testbench for the adaptive biquad filter block
// assumes 10 MHz clock and flat filters after reset
`timescale 1ns/1ps
module dabf_top_bench;
	logic clk;
	logic srst;
	logic [7:0] reg_page;
	logic [6:0] reg_addr;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic in_valid;
	logic in_ready;
	logic out_valid;
	dabf_pkg::dabf_sample_t in_sample;
	dabf_pkg::dabf_sample_t out_sample;
	dabf_pkg::dabf_sample_t last_out;
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	int n_out = 0;
	logic [15:0] v;
	logic [7:0] b;

	dabf_top #(.FIFO_DEPTH(16)) i_dabf_top (.clk(clk), .srst(srst), .reg_page(reg_page), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.in_valid(in_valid), .in_ready(in_ready), .in_sample(in_sample), .out_valid(out_valid),
		.out_sample(out_sample));
	dabf_host i_dabf_host (.clk(clk), .reg_page(reg_page), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			num_errors++;
			stop_test();
		end
	end
	always @(negedge clk) begin
		if (out_valid === 1'b1) begin
			n_out++;
			last_out = out_sample;
		end
	end

	task automatic stop_test();
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic push(input logic [15:0] l, input logic [15:0] r);
		int g;
		@(posedge clk);
		#1;
		in_sample = {l, r};
		in_valid = 1'b1;
		g = 0;
		while (in_ready !== 1'b1 && g < 100) begin
			@(posedge clk);
			#1;
			g++;
		end
		@(posedge clk);
		#1;
		in_valid = 1'b0;
		in_sample = ~in_sample;
	endtask
	task automatic wait_out(input int n);
		int g;
		g = 0;
		while (n_out < n && g < 200) begin
			@(posedge clk);
			g++;
		end
		chk(16'(n_out), 16'(n));
	endtask

	task automatic t_reset();
		logic [7:0] pg [6] = '{8'h08, 8'h08, 8'h09, 8'h09, 8'h0c, 8'h0d};
		logic [6:0] ad [6] = '{7'h02, 7'h7c, 7'h08, 7'h0c, 7'h42, 7'h04};
		logic [15:0] ex [6] = '{16'h7fff, 16'h0000, 16'h7fff, 16'h0000, 16'h7fff, 16'h0000};
		i_dabf_host.rd(8'h08, 7'h01, b);
		chk({8'h00, b}, 16'h0000);
		chk({15'h0, i_dabf_host.rd_ok}, 16'h0001);
		for (int i = 0; i < 6; i++) begin
			i_dabf_host.rcoef(pg[i], ad[i], v);
			chk(v, ex[i]);
		end
	endtask
	// flat taps drop a positive sample by one lsb per step
	task automatic t_chains();
		logic [7:0] ch [6] = '{8'h12, 8'h13, 8'h15, 8'h16, 8'h17, 8'h19};
		logic [15:0] st [6] = '{16'h5, 16'h5, 16'h5, 16'h5, 16'h2, 16'h6};
		i_dabf_host.wr(8'h00, 7'h3f, 8'h80);
		for (int i = 0; i < 6; i++) begin
			i_dabf_host.wr(8'h00, 7'h10, ch[i]);
			push(16'h4000, 16'h0100);
			wait_out(n_out + 1);
			chk(last_out.left, 16'h4000 - st[i]);
			chk(last_out.right, 16'h0100 - st[i]);
		end
	endtask
	task automatic t_fifo();
		int n0;
		i_dabf_host.wr(8'h00, 7'h10, 8'h17);
		i_dabf_host.wr(8'h00, 7'h3f, 8'h00);
		n0 = n_out;
		for (int i = 0; i < 16; i++) begin
			push(16'h4000, 16'hc000);
		end
		chk({15'h0, in_ready}, 16'h0000);
		chk(16'(n_out), 16'(n0));
		i_dabf_host.wr(8'h00, 7'h3f, 8'h40);
		wait_out(n0 + 16);
		chk({15'h0, in_ready}, 16'h0001);
		chk(last_out.left, 16'h3ffe);
		chk(last_out.right, 16'hc000);
		i_dabf_host.wr(8'h00, 7'h3f, 8'h00);
	endtask
	task automatic t_stopped();
		logic [7:0] pg [5] = '{8'h08, 8'h0c, 8'h08, 8'h0d, 8'h09};
		logic [6:0] ad [5] = '{7'h04, 7'h04, 7'h7c, 7'h0c, 7'h0e};
		logic [15:0] ex [5] = '{16'h1234, 16'h5678, 16'h9abc, 16'h8000, 16'h0000};
		for (int i = 0; i < 5; i++) begin
			i_dabf_host.wcoef(pg[i], ad[i], ex[i] | 16'(i == 4));
		end
		for (int i = 0; i < 5; i++) begin
			i_dabf_host.rcoef(pg[i], ad[i], v);
			chk(v, ex[i]);
		end
	endtask
	task automatic t_locked();
		i_dabf_host.wr(8'h00, 7'h3f, 8'h80);
		i_dabf_host.wcoef(8'h08, 7'h04, 16'haaaa);
		i_dabf_host.rcoef(8'h08, 7'h04, v);
		chk(v, 16'h0000);
		i_dabf_host.wr(8'h08, 7'h01, 8'h01);
		i_dabf_host.rd(8'h08, 7'h01, b);
		chk({8'h00, b}, 16'h0000);
		i_dabf_host.wr(8'h00, 7'h3f, 8'h00);
		i_dabf_host.rcoef(8'h08, 7'h04, v);
		chk(v, 16'h1234);
	endtask
	task automatic t_adaptive();
		i_dabf_host.wr(8'h08, 7'h01, 8'h04);
		i_dabf_host.wr(8'h00, 7'h3f, 8'hc0);
		i_dabf_host.rd(8'h08, 7'h01, b);
		chk({8'h00, b}, 16'h0004);
		i_dabf_host.wcoef(8'h08, 7'h06, 16'h0abc);
		i_dabf_host.wr(8'h08, 7'h01, 8'h05);
		i_dabf_host.rd(8'h08, 7'h01, b);
		chk({15'h0, b[1]}, 16'h0000);
		push(16'h4000, 16'h0100);
		wait_out(n_out + 1);
		i_dabf_host.rd(8'h08, 7'h01, b);
		chk({8'h00, b}, 16'h0006);
		i_dabf_host.wcoef(8'h0c, 7'h08, 16'h1111);
		i_dabf_host.wr(8'h00, 7'h3f, 8'h00);
		i_dabf_host.rcoef(8'h0c, 7'h06, v);
		chk(v, 16'h0abc);
		i_dabf_host.rcoef(8'h08, 7'h06, v);
		chk(v, 16'h0000);
		i_dabf_host.rcoef(8'h08, 7'h08, v);
		chk(v, 16'h1111);
		i_dabf_host.rcoef(8'h0c, 7'h08, v);
		chk(v, 16'h0000);
	endtask

	initial begin
		srst = 1'b1;
		in_valid = 1'b0;
		in_sample = '0;
		repeat (10) @(posedge clk);
		#1;
		srst = 1'b0;
		t_reset();
		t_chains();
		t_fifo();
		t_stopped();
		t_locked();
		t_adaptive();
		stop_test();
	end
endmodule
